// ### verilog/jlc_link_control.sv
/*
 link control bank with sample-lsb marker insertion and a 4-word output fifo.
 assumes an apb master at 100 mhz and a converter that supplies one sample a cycle.
*/
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps

// ==========================================================
// fifo
module jlc_fifo #(
   parameter int width = 13,
   parameter int depth = 4
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic flush,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [width-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [width-1:0] out_data
);
   localparam int aw = $clog2(depth);
   logic [width-1:0] mem [depth];
   logic [aw-1:0] wr_ptr;
   logic [aw-1:0] rd_ptr;
   logic [aw:0] count;
   logic push;
   logic pop;

   // handshakes
   assign in_ready = (count != (aw+1)'(depth));
   assign out_valid = (count != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr];

   // storage
   always_ff @(posedge pclk)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   // pointers; flush empties it when the link drops
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else if (flush)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= (wr_ptr == aw'(depth-1)) ? '0 : aw'(wr_ptr + 1'b1);
         if (pop)
            rd_ptr <= (rd_ptr == aw'(depth-1)) ? '0 : aw'(rd_ptr + 1'b1);
         count <= (aw+1)'(count + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0));
      end
   end
endmodule : jlc_fifo

// ==========================================================
// top
module jlc_link_control #(
   parameter int fifo_depth = 4,
   parameter int latency = jlc_pkg::path_latency
) (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // converter input
   input wire logic [11:0] adc_sample,
   input wire logic adc_valid,
   output logic adc_ready,
   input wire logic marker_in,
   input wire logic cal_state_in,
   input wire logic sysref,
   // transport output
   output logic [11:0] tx_sample,
   output logic tx_valid,
   input wire logic tx_ready,
   // link side effects
   output logic link_reset_n,
   output logic serializer_powerdown,
   output logic link_clock_gate_en,
   output logic [4:0] multiframe_count,
   output logic [4:0] ila_control_bits
);
   logic [7:0] link_enable;
   logic [7:0] output_mode;
   logic [7:0] multiframe;
   logic [7:0] sync_request;
   logic [7:0] link_control;
   logic [7:0] test_pattern;
   logic [7:0] device_id;
   logic [7:0] frame_char;
   logic [7:0] powerdown;
   logic [7:0] extra_a;
   logic [7:0] extra_b;
   logic [7:0] lsb_marker;
   logic [7:0] cal_control;
   logic [11:0] idx;
   logic wr;
   logic byte0;
   logic known;
   logic en;
   logic [7:0] rd_byte;
   jlc_pkg::jlc_sample_t pipe [latency];
   logic pipe_valid [latency];
   jlc_pkg::jlc_sample_t fifo_in;
   jlc_pkg::jlc_sample_t fifo_out;
   logic fifo_in_ready;
   logic stall;
   logic bypass;
   logic eight_bit;
   logic [11:0] next_data;

   // decode; word index is byte address over four
   assign idx = paddr[13:2];
   assign byte0 = pstrb[0];
   assign wr = psel && penable && pwrite && byte0;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign en = link_enable[jlc_pkg::enable_bit];

   // known addresses; reserved words read zero
   always_comb
   begin
      known = 1'b1;
      unique case (idx)
         jlc_pkg::idx_link_enable: rd_byte = link_enable;
         jlc_pkg::idx_output_mode: rd_byte = output_mode;
         jlc_pkg::idx_multiframe: rd_byte = multiframe;
         jlc_pkg::idx_sync_request: rd_byte = sync_request;
         jlc_pkg::idx_link_control: rd_byte = link_control;
         jlc_pkg::idx_test_pattern: rd_byte = test_pattern;
         jlc_pkg::idx_device_id: rd_byte = device_id;
         jlc_pkg::idx_frame_char: rd_byte = frame_char;
         jlc_pkg::idx_status: rd_byte = {7'h00, en};
         jlc_pkg::idx_powerdown: rd_byte = powerdown;
         jlc_pkg::idx_extra_a: rd_byte = extra_a;
         jlc_pkg::idx_extra_b: rd_byte = extra_b;
         jlc_pkg::idx_lsb_marker: rd_byte = lsb_marker;
         jlc_pkg::idx_cal_control: rd_byte = cal_control;
         default:
         begin
            rd_byte = jlc_pkg::rst_zero;
            known = 1'b0;
         end
      endcase
   end

   // read data register; unmapped reads return zero without error
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= '0;
      else if (psel && !penable && !pwrite)
         prdata <= known ? {24'h000000, rd_byte} : '0;
   end

   // link enable, multiframe, lsb marker, cal control and the registers that only store; reserved bits forced low
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         link_enable <= jlc_pkg::rst_link_enable;
         multiframe <= jlc_pkg::rst_multiframe;
         sync_request <= jlc_pkg::rst_sync_request;
         link_control <= jlc_pkg::rst_link_control;
         test_pattern <= jlc_pkg::rst_zero;
         device_id <= jlc_pkg::rst_zero;
         frame_char <= jlc_pkg::rst_zero;
         powerdown <= jlc_pkg::rst_zero;
         extra_a <= jlc_pkg::rst_zero;
         extra_b <= jlc_pkg::rst_zero;
         lsb_marker <= jlc_pkg::rst_zero;
         cal_control <= jlc_pkg::rst_zero;
      end
      else if (wr)
      begin
         unique case (idx)
            jlc_pkg::idx_link_enable: link_enable <= pwdata[7:0] & jlc_pkg::mask_enable;
            jlc_pkg::idx_multiframe: multiframe <= pwdata[7:0] & jlc_pkg::mask_five;
            jlc_pkg::idx_sync_request: sync_request <= pwdata[7:0];
            jlc_pkg::idx_link_control: link_control <= pwdata[7:0];
            jlc_pkg::idx_test_pattern: test_pattern <= pwdata[7:0];
            jlc_pkg::idx_device_id: device_id <= pwdata[7:0];
            jlc_pkg::idx_frame_char: frame_char <= pwdata[7:0];
            jlc_pkg::idx_powerdown: powerdown <= pwdata[7:0];
            jlc_pkg::idx_extra_a: extra_a <= pwdata[7:0];
            jlc_pkg::idx_extra_b: extra_b <= pwdata[7:0];
            jlc_pkg::idx_lsb_marker: lsb_marker <= pwdata[7:0] & jlc_pkg::mask_enable;
            jlc_pkg::idx_cal_control: cal_control <= pwdata[7:0] & jlc_pkg::mask_cal;
            default: ;
         endcase
      end
   end

   // output mode; low five bits stored as written, ordering is software's job
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         output_mode <= jlc_pkg::rst_output_mode;
      else if (wr && idx == jlc_pkg::idx_output_mode)
         output_mode <= pwdata[7:0] & jlc_pkg::mask_five;
   end

   // side effects of a disabled link
   assign link_reset_n = en;
   assign serializer_powerdown = !en;
   assign link_clock_gate_en = en;
   assign ila_control_bits = jlc_pkg::ila_cs_zero;

   // local multiframe counter; sysref realigns only while enabled
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         multiframe_count <= '0;
      else if (!en || sysref)
         multiframe_count <= '0;
      else if (multiframe_count == multiframe[4:0])
         multiframe_count <= '0;
      else
         multiframe_count <= 5'(multiframe_count + 1'b1);
   end

   // sample pipeline; marker travels beside its sample so both match
   assign stall = !fifo_in_ready;
   assign adc_ready = en && !stall;
   generate
      for (genvar i = 0; i < latency; i++)
      begin : g_pipe
         if (i == 0)
         begin : g_head
            // first stage; receiver gate drops the marker if software forgets it
            always_ff @(posedge pclk or negedge presetn)
            begin
               if (!presetn)
               begin
                  pipe[i] <= '0;
                  pipe_valid[i] <= 1'b0;
               end
               else if (!en)
                  pipe_valid[i] <= 1'b0;
               else if (!stall)
               begin
                  pipe[i].data <= adc_sample;
                  pipe[i].marker <= marker_in && cal_control[jlc_pkg::marker_rx_bit];
                  pipe_valid[i] <= adc_valid;
               end
            end
         end
         else
         begin : g_tail
            // later stages move sample and marker as one word, so they cannot slip
            always_ff @(posedge pclk or negedge presetn)
            begin
               if (!presetn)
               begin
                  pipe[i] <= '0;
                  pipe_valid[i] <= 1'b0;
               end
               else if (!en)
                  pipe_valid[i] <= 1'b0;
               else if (!stall)
               begin
                  pipe[i] <= pipe[i-1];
                  pipe_valid[i] <= pipe_valid[i-1];
               end
            end
         end
      end
   endgenerate

   // lsb substitution; marker beats calibration flag in bypass modes only
   assign bypass = (output_mode[4:0] <= jlc_pkg::mode_bypass_max);
   assign eight_bit = (output_mode[4:0] >= jlc_pkg::mode_eight_bit_min);
   always_comb
   begin
      next_data = pipe[latency-1].data;
      if (lsb_marker[jlc_pkg::marker_bit] && bypass)
      begin
         if (eight_bit)
            next_data[4] = pipe[latency-1].marker;
         else
            next_data[0] = pipe[latency-1].marker;
      end
      else if (cal_control[jlc_pkg::cal_state_flag_bit])
      begin
         if (eight_bit)
            next_data[4] = cal_state_in;
         else
            next_data[0] = cal_state_in;
      end
   end
   assign fifo_in.data = next_data;
   assign fifo_in.marker = pipe[latency-1].marker;

   jlc_fifo #(
      .width(jlc_pkg::sample_w),
      .depth(fifo_depth)
   ) u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .flush(!en),
      .in_valid(pipe_valid[latency-1] && en),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(fifo_out)
   );

   // 8-bit samples sit in the top byte of the 12-bit word
   assign tx_sample = fifo_out.data;
endmodule : jlc_link_control

// ### verilog/jlc_pkg.sv
/*
 link control bank package: register indices, field positions, reset values,
 stream carrier types and timing counts.
 assumes a 32-bit apb slave with one aligned word per register.
*/
package jlc_pkg;
   // ==========================================================
   // register indices (byte address is four times the index)
   localparam logic [11:0] idx_link_enable = 12'h200;
   localparam logic [11:0] idx_output_mode = 12'h201;
   localparam logic [11:0] idx_multiframe = 12'h202;
   localparam logic [11:0] idx_sync_request = 12'h203;
   localparam logic [11:0] idx_link_control = 12'h204;
   localparam logic [11:0] idx_test_pattern = 12'h205;
   localparam logic [11:0] idx_device_id = 12'h206;
   localparam logic [11:0] idx_frame_char = 12'h207;
   localparam logic [11:0] idx_status = 12'h208;
   localparam logic [11:0] idx_powerdown = 12'h209;
   localparam logic [11:0] idx_extra_a = 12'h20a;
   localparam logic [11:0] idx_extra_b = 12'h20b;
   localparam logic [11:0] idx_bank_last = 12'h20f;
   localparam logic [11:0] idx_lsb_marker = 12'h160;
   localparam logic [11:0] idx_cal_control = 12'h061;
   // ==========================================================
   // reset values
   localparam logic [7:0] rst_link_enable = 8'h01;
   localparam logic [7:0] rst_output_mode = 8'h02;
   localparam logic [7:0] rst_multiframe = 8'h1f;
   localparam logic [7:0] rst_sync_request = 8'h01;
   localparam logic [7:0] rst_link_control = 8'h02;
   localparam logic [7:0] rst_zero = 8'h00;
   // ==========================================================
   // field layout
   localparam int enable_bit = 0;
   localparam int marker_bit = 0;
   localparam int cal_en_bit = 0;
   localparam int cal_state_flag_bit = 1;
   localparam int marker_rx_bit = 2;
   localparam logic [7:0] mask_enable = 8'h01;
   localparam logic [7:0] mask_five = 8'h1f;
   localparam logic [7:0] mask_cal = 8'h07;
   localparam logic [4:0] mode_bypass_max = 5'h03;
   localparam logic [4:0] mode_eight_bit_min = 5'h0a;
   localparam logic [4:0] ila_cs_zero = 5'h00;
   // ==========================================================
   // stream carrier
   typedef struct packed {
      logic [11:0] data;
      logic marker;
   } jlc_sample_t;
   localparam int sample_w = 13;
   localparam int path_latency = 4;
endpackage : jlc_pkg

// ### verif/jlc_link_control_props.sv
/*
 checker on the link control top ports.
 assumes it is bound to every instance of the top.
*/
`timescale 1ns/1ps
// ==========
// checker
module jlc_link_control_props (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pready,
   input wire logic pslverr,
   // stream
   input wire logic adc_valid,
   input wire logic adc_ready,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [11:0] tx_sample,
   // side effects
   input wire logic link_reset_n,
   input wire logic serializer_powerdown,
   input wire logic link_clock_gate_en,
   input wire logic [4:0] multiframe_count,
   input wire logic [4:0] ila_control_bits
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // a taken sample, then the link kept up over the pipe
   sequence s_take;
      adc_valid && adc_ready;
   endsequence
   sequence s_up;
      link_reset_n [*5];
   endsequence
   a_side_effects: assert property (link_reset_n == link_clock_gate_en && link_reset_n != serializer_powerdown)
      else $error("link side effects disagree");
   a_count_reset: assert property (!link_reset_n && !$past(link_reset_n) |-> multiframe_count == 5'h00)
      else $error("multiframe count runs while disabled");
   a_ila_zero: assert property (ila_control_bits == 5'h00)
      else $error("ila control bits not zero");
   a_slave_ready: assert property (pready && !pslverr)
      else $error("apb answer not ready or error");
   a_adc_gated: assert property (!link_reset_n |-> !adc_ready)
      else $error("samples taken while disabled");
   a_tx_flushed: assert property (!link_reset_n [*2] |-> !tx_valid)
      else $error("output not flushed while disabled");
   a_tx_hold: assert property (tx_valid && !tx_ready ##1 link_reset_n |-> tx_valid && $stable(tx_sample))
      else $error("stalled sample changed");
   a_sample_lands: assert property (s_take ##1 s_up |-> tx_valid)
      else $error("sample missing after pipe latency");
endmodule : jlc_link_control_props

bind jlc_link_control jlc_link_control_props u_props (.pclk(pclk), .presetn(presetn),
   .pready(pready), .pslverr(pslverr), .adc_valid(adc_valid), .adc_ready(adc_ready),
   .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_sample(tx_sample),
   .link_reset_n(link_reset_n), .serializer_powerdown(serializer_powerdown),
   .link_clock_gate_en(link_clock_gate_en), .multiframe_count(multiframe_count),
   .ila_control_bits(ila_control_bits));

// ### verif/jlc_rx_model.sv
/*
 link receiver model: takes transport samples and logs them.
 assumes the bench sets stall to make back-pressure.
*/
`timescale 1ns/1ps
// ==========
// receiver
module jlc_rx_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // stream
   input wire logic [11:0] tx_sample,
   input wire logic tx_valid,
   output logic tx_ready,
   // bench control
   input wire logic stall
);
   logic [11:0] got [$];
   // never ready in reset, so nothing is taken before the link is up
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) tx_ready <= 1'b0;
      else tx_ready <= !stall;
   // accepts any format the link sends, in order
   always @(posedge pclk)
      if (presetn && tx_valid && tx_ready) got.push_back(tx_sample);
endmodule : jlc_rx_model

// ### verif/jlc_link_control_tb.sv
/*
 bench for the link control bank: apb tasks, sample bursts, receiver model.
 assumes zero-wait apb and the index map of the package.
*/
`timescale 1ns/1ps
// ==========
// bench
module jlc_link_control_tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdat;
   logic [3:0] pstrb = 4'hf;
   logic [11:0] adc_sample = 12'h0, tx_sample;
   logic adc_valid = 1'b0, marker_in = 1'b0, cal_state_in = 1'b0, sysref = 1'b0;
   logic stall = 1'b1, pready, pslverr, adc_ready, tx_valid, tx_ready;
   logic link_reset_n, serializer_powerdown, link_clock_gate_en;
   logic [4:0] multiframe_count, ila_control_bits;
   logic [7:0] rv [12] = '{8'h01, 8'h02, 8'h1f, 8'h01, 8'h02, 8'h00,
      8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
   logic [11:0] exp_q [$];
   int error_cnt = 0, comparisons = 0;
   jlc_link_control u_jlc_link_control (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .adc_sample, .adc_valid,
      .adc_ready, .marker_in, .cal_state_in, .sysref, .tx_sample, .tx_valid, .tx_ready,
      .link_reset_n, .serializer_powerdown, .link_clock_gate_en, .multiframe_count,
      .ila_control_bits);
   jlc_rx_model u_jlc_rx_model (.pclk, .presetn, .tx_sample, .tx_valid, .tx_ready, .stall);
   // 100 mhz clock
   initial
   begin
      forever #5 pclk = ~pclk;
   end
   // one apb transfer; read data taken at the edge that sees pready
   task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {18'h0, idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR %0t value %h expected %h", $time, g, e);
      end
   endtask : chk_reg
   task automatic chk_smp(input logic [11:0] g, input logic [11:0] e);
      comparisons++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR %0t sample %h expected %h", $time, g, e);
      end
   endtask : chk_smp
   task automatic rd(input logic [11:0] idx, input logic [7:0] e);
      apb(1'b0, idx, 8'h00);
      chk_reg(rdat, {24'h0, e});
   endtask : rd
   // eight samples into a stalled receiver: fifo must refuse, then drain in order
   task automatic burst(input logic [1:0] k);
      fork
         begin
            for (int i = 0; i < 8; i++)
            begin
               logic [11:0] s;
               s = 12'h5a3 + 12'(i * 37);
               adc_sample <= s;
               marker_in <= i[0];
               adc_valid <= 1'b1;
               // 1: marker on bit 0; 2: calibration flag on the lsb of the top byte
               exp_q.push_back((k == 2'd1) ? {s[11:1], i[0]} :
                  (k == 2'd2) ? {s[11:5], 1'b1, s[3:0]} : s);
               do @(negedge pclk); while (adc_ready !== 1'b1);
               @(posedge pclk);
            end
            adc_valid <= 1'b0;
         end
         begin
            repeat (30) @(posedge pclk);
            chk_reg(32'(adc_ready), 32'h0);
            stall <= 1'b0;
         end
      join
      repeat (20) @(posedge pclk);
      stall <= 1'b1;
      chk_reg(u_jlc_rx_model.got.size(), 32'h8);
      while (exp_q.size() > 0 && u_jlc_rx_model.got.size() > 0)
         chk_smp(u_jlc_rx_model.got.pop_front(), exp_q.pop_front());
      exp_q.delete();
   endtask : burst
   task report_and_stop;
      $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop
   // watchdog well past the expected run length
   initial
   begin
      repeat (5000) @(posedge pclk);
      error_cnt++;
      $display("ERROR %0t watchdog expired", $time);
      report_and_stop;
   end
   // main sequence
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk_reg(32'(link_reset_n), 32'h1);
      for (int i = 0; i < 12; i++)
         rd(12'h200 + 12'(i), rv[i]);
      apb(1'b1, 12'h20c, 8'h5a);
      rd(12'h20c, 8'h00);
      apb(1'b1, 12'h200, 8'h00);
      @(negedge pclk);
      chk_reg(32'({link_reset_n, serializer_powerdown, link_clock_gate_en}), 32'h2);
      apb(1'b1, 12'h201, 8'hff);
      rd(12'h201, 8'h1f);
      apb(1'b1, 12'h202, 8'hff);
      rd(12'h202, 8'h1f);
      apb(1'b1, 12'h201, 8'h00);
      apb(1'b1, 12'h202, 8'h03);
      apb(1'b1, 12'h061, 8'h07);
      apb(1'b1, 12'h160, 8'hff);
      rd(12'h160, 8'h01);
      apb(1'b1, 12'h200, 8'hff);
      rd(12'h200, 8'h01);
      cal_state_in <= 1'b1;
      burst(2'd1);
      sysref <= 1'b1;
      @(posedge pclk);
      sysref <= 1'b0;
      repeat (12)
      begin
         @(negedge pclk);
         chk_reg(32'(multiframe_count > 5'h03), 32'h0);
      end
      apb(1'b1, 12'h200, 8'h00);
      // one sysref, then three free edges: a running counter would reach three
      sysref <= 1'b1;
      @(posedge pclk);
      sysref <= 1'b0;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk_reg(32'(multiframe_count), 32'h0);
      apb(1'b1, 12'h160, 8'h00);
      apb(1'b1, 12'h061, 8'h01);
      apb(1'b1, 12'h200, 8'h01);
      burst(2'd0);
      // 8-bit decimating mode: no marker, the calibration flag takes the byte lsb
      apb(1'b1, 12'h200, 8'h00);
      apb(1'b1, 12'h061, 8'h00);
      apb(1'b1, 12'h201, 8'h0a);
      apb(1'b1, 12'h160, 8'h01);
      apb(1'b1, 12'h061, 8'h03);
      apb(1'b1, 12'h200, 8'h01);
      burst(2'd2);
      report_and_stop;
   end
endmodule : jlc_link_control_tb
